// ### dv/fcs_host.sv
`timescale 1ns/100ps
// Host processor model that drives the byte register port
module fcs_host (
    input wire logic clk,
    input wire logic [7:0] bus_rdata,
    output logic [3:0] bus_addr,
    output logic [7:0] bus_wdata,
    output logic bus_wr,
    output logic bus_rd
);
    // Idle bus from time zero
    initial begin
        bus_addr = 4'h0;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
    end

    // One-cycle write strobe; released data shows the inverse so stale bytes never match
    task automatic wr(input logic [3:0] a, input logic [7:0] dat);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= dat;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
        bus_wdata <= ~dat;
    endtask

    // One-cycle read strobe; data is taken mid-cycle of the following cycle
    task automatic rd(input logic [3:0] a, output logic [7:0] dat);
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        @(negedge clk);
        dat = bus_rdata;
    endtask
endmodule

// ### dv/floppy_cmd_status_regs_test.sv
`timescale 1ns/100ps
// Self-checking bench for the floppy command and status block
module floppy_cmd_status_regs_test;
    logic clk, rst_n, irq, step_n, dir_n, head_n, motor_a_on_n, motor_b_on_n, bus_wr, bus_rd;
    logic hard_reset_pin, track_zero_n, index_n, write_prot_n, read_data_n, second_drive_n;
    logic disk_change_n, write_data_n, write_gate_n, dma_req;
    logic [3:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata, d, b0, s0, s1, c, p, tgt;
    logic [1:0] drive_sel;
    int err_total, samples_checked, n, m, steps;

    fcs_top i_dut (.clk(clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq), .hard_reset_pin(hard_reset_pin),
        .track_zero_n(track_zero_n), .index_n(index_n), .write_prot_n(write_prot_n), .read_data_n(read_data_n),
        .second_drive_n(second_drive_n), .disk_change_n(disk_change_n), .write_data_n(write_data_n),
        .write_gate_n(write_gate_n), .dma_req(dma_req), .step_n(step_n), .dir_n(dir_n), .head_n(head_n),
        .motor_a_on_n(motor_a_on_n), .motor_b_on_n(motor_b_on_n), .drive_sel(drive_sel));
    fcs_host i_host (.clk(clk), .bus_rdata(bus_rdata), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Count step pulses seen on the drive pin
    always @(negedge step_n) steps++;

    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Command and parameter bytes to the FIFO offset
    task automatic send(input logic [7:0] q[$]);
        foreach (q[i]) i_host.wr(4'h5, q[i]);
    endtask

    // Read result bytes and compare them in order
    task automatic expect_res(input logic [7:0] q[$]);
        foreach (q[i]) begin
            i_host.rd(4'h5, d);
            check(d, q[i]);
        end
    endtask

    // Poll the event status until the given bits are set, bounded
    task automatic wait_ev(input logic [7:0] bitm);
        for (int k = 0; k < 400; k++) begin
            i_host.rd(4'h8, d);
            if ((d & bitm) === bitm) return;
        end
        err_total++;
        print_verdict();
    endtask

    // Low pulses on the data pins, each ending in a rising edge
    task automatic pulse_pins(input int nw, input int nr);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            write_data_n <= (k >= nw);
            read_data_n <= (k >= nr);
            repeat (4) @(posedge clk);
            write_data_n <= 1'b1;
            read_data_n <= 1'b1;
            repeat (4) @(posedge clk);
        end
    endtask

    // Counts, verdict and end of run
    task automatic print_verdict();
        $display("Compared %0d values, %0d mismatches", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        hard_reset_pin = 1'b0;
        {track_zero_n, index_n, write_prot_n, read_data_n, second_drive_n, disk_change_n} = 6'h3F;
        {write_data_n, write_gate_n, dma_req} = 3'h6;
        void'($urandom(96));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        {second_drive_n, track_zero_n, index_n, write_prot_n, dma_req, write_gate_n} <= 6'($urandom());
        disk_change_n <= 1'($urandom());
        @(negedge clk);
        check({drive_sel, motor_a_on_n, motor_b_on_n, step_n}, 8'h07);
        i_host.wr(4'h9, 8'h00);
        send('{8'h00});
        expect_res('{8'h80});
        check(irq, 1'b0);
        i_host.wr(4'h8, 8'h07);
        i_host.wr(4'h9, 8'h07);
        send('{8'hFF});
        expect_res('{8'h80});
        i_host.rd(4'h0, d);
        check(d[7], 1'b1);
        i_host.wr(4'h8, 8'h07);
        i_host.rd(4'h0, d);
        check({d[7], irq}, 8'h00);
        $display("Invalid code and interrupt test done");
        send('{8'h14});
        expect_res('{8'h00});
        send('{8'h94});
        expect_res('{8'h10});
        s0 = 8'($urandom());
        s1 = 8'($urandom());
        c = 8'($urandom()) & 8'h7F;
        p = 8'($urandom());
        send('{8'h03, s0, s1});
        send('{8'h13, 8'h00, c, p});
        i_host.rd(4'h5, d);
        check(d, 8'h00);
        $display("Lock, specify and configure test done");
        i_host.wr(4'h8, 8'h07);
        tgt = 8'(2 + $urandom() % 3);
        send('{8'h0F, 8'h05, tgt});
        wait_ev(8'h01);
        check(8'(steps), tgt);
        check({head_n, dir_n, step_n}, 8'h01);
        i_host.rd(4'h0, d);
        check(d, {1'b1, second_drive_n, 1'b0, track_zero_n, 1'b1, index_n, write_prot_n, 1'b1});
        send('{8'h08});
        expect_res('{8'h25, tgt});
        i_host.wr(4'h8, 8'h07);
        i_host.wr(4'hA, 8'h01);
        i_host.rd(4'h0, d);
        check(d & 8'hDF, {1'b0, dma_req, 1'b0, ~track_zero_n, 1'b0, ~index_n, ~write_prot_n, 1'b0});
        i_host.wr(4'hA, 8'h00);
        send('{8'h04, 8'h05});
        i_host.rd(4'h5, d);
        check(d, {1'b0, ~write_prot_n, 1'b1, ~track_zero_n, 4'hD});
        send('{8'h12, 8'h8F});
        send('{8'hCF, 8'h05, 8'h01});
        wait_ev(8'h01);
        check(8'(steps), tgt + 8'h01);
        send('{8'h08});
        expect_res('{8'h25, tgt + 8'h01});
        send('{8'h0E});
        expect_res('{8'h00, tgt + 8'h01, 8'h00, 8'h00, s0, s1, 8'h00, 8'h8F, c, p});
        $display("Seek, sense and dump test done");
        i_host.wr(4'h2, 8'h11);
        @(negedge clk);
        check({drive_sel, motor_a_on_n, motor_b_on_n}, 8'h05);
        i_host.rd(4'h1, b0);
        n = 1 + $urandom() % 4;
        m = 1 + $urandom() % 4;
        pulse_pins(n, m);
        i_host.rd(4'h1, d);
        check((d ^ b0) & 8'h18, {3'b000, n[0], m[0], 3'b000});
        check(d & 8'h27, {2'b00, 1'b1, 2'b00, ~write_gate_n, 2'b01});
        @(posedge clk);
        hard_reset_pin <= 1'b1;
        @(posedge clk);
        hard_reset_pin <= 1'b0;
        repeat (4) @(posedge clk);
        i_host.rd(4'h1, d);
        check({d[5], drive_sel, motor_a_on_n}, 8'h01);
        $display("Status B and hard reset test done");
        i_host.wr(4'h3, 8'h02);
        i_host.rd(4'h3, d);
        check(d & 8'h03, 8'h02);
        i_host.rd(4'h6, d);
        check(d, 8'h00);
        $display("Register map test done");
        print_verdict();
    end
endmodule

// ### src/fcs_consts.svh
`ifndef FCS_CONSTS_SVH
`define FCS_CONSTS_SVH

// Register offsets
`define FCS_A_SA 4'h0
`define FCS_A_SB 4'h1
`define FCS_A_DO 4'h2
`define FCS_A_TD 4'h3
`define FCS_A_MS 4'h4
`define FCS_A_FIFO 4'h5
`define FCS_A_DI 4'h7
`define FCS_A_ISTS 4'h8
`define FCS_A_IMASK 4'h9
`define FCS_A_MODE 4'hA

// Command codes and masks
`define FCS_OP_SINT 8'h08
`define FCS_OP_SPEC 8'h03
`define FCS_OP_SEEK 8'h0F
`define FCS_OP_CFG 8'h13
`define FCS_OP_RSEEK 8'h8F
`define FCS_RSEEK_MASK 8'hBF
`define FCS_OP_DUMP 8'h0E
`define FCS_OP_PERP 8'h12
`define FCS_OP_LOCK 8'h14
`define FCS_LOCK_MASK 8'h7F
`define FCS_OP_SDRV 8'h04

// Result values
`define FCS_ST0_INV 8'h80
`define FCS_ST0_SEEKEND 8'h20
`define FCS_DUMP_LEN 4'hA

// Event bits of the interrupt status register
`define FCS_EV_SEEK 0
`define FCS_EV_RES 1
`define FCS_EV_INV 2

// Step timing
`define FCS_CLK_MHZ 25
`define FCS_STEP_US 4
`define FCS_STEP_CYC (`FCS_STEP_US * `FCS_CLK_MHZ)
`define FCS_STEP_LOW 8'h01

`endif

// ### src/fcs_pkg.sv
package fcs_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_PARAM, ST_SEEK, ST_RESULT} fcs_st_t;
    typedef enum logic [3:0] {
        K_INV, K_SINT, K_SPEC, K_SEEK, K_CFG, K_RSEEK, K_DUMP, K_PERP, K_LOCK, K_SDRV
    } fcs_kind_t;
    typedef struct packed {
        logic mr;
        logic dskchg_n;
        logic second_drive_n_n;
        logic rdata_n;
        logic wp_n;
        logic index_n;
        logic trk0_n;
    } fcs_pins_t;
    typedef struct packed {
        fcs_pins_t s1;
        fcs_pins_t s2;
        logic rd_prev;
        logic wd_prev;
        logic rd_tog;
        logic wd_tog;
        logic step_latch_n;
        fcs_st_t st;
        fcs_kind_t kind;
        logic rdir;
        logic [1:0] pleft;
        logic [1:0] pidx;
        logic [2:0][7:0] p;
        logic [9:0][7:0] res;
        logic [3:0] res_n;
        logic [3:0] res_i;
        logic [3:0][7:0] present_cylinder;
        logic [7:0] tgt;
        logic [1:0] drv;
        logic head_n;
        logic dir_n;
        logic step_n;
        logic [7:0] stp_cnt;
        logic [7:0] st0;
        logic seek_pend;
        logic [7:0] spec0;
        logic [7:0] spec1;
        logic [7:0] cfg;
        logic [7:0] precomp_start_track;
        logic [7:0] perp;
        logic lock;
        logic [7:0] dor;
        logic mota_n;
        logic motb_n;
        logic [1:0] td;
        logic nopre;
        logic [1:0] rate;
        logic [2:0] ists;
        logic [2:0] imask;
        logic irq;
        logic layout;
        logic [7:0] rdata;
    } fcs_state_t;
endpackage

// ### src/fcs_top.sv
`timescale 1ns/100ps
`include "fcs_consts.svh"

// What this block does
// - Interrupt-sense returns status byte zero, then present cylinder of the seeked drive.
// - Seek takes opcode, head/drive byte, target cylinder; head then steps there.
// - Register dump returns ten bytes: cylinders, timings, sector count, modes, precomp track.
// - Drive-status sense takes head/drive byte, answers one drive sense byte.
// - Undefined opcode: no operation, back to standby, one result byte 80H.
// - Offsets 0..5 and 7 decode status, control, rate, FIFO, input and config registers.
// - Status A bit 7 shows the interrupt output level in both layouts.
// - First layout: status A bit 6 is 0 when second drive installed.
// - First layout: status A bit 5 inverse step output, bit 4 track-zero pin.
// - First layout: status A bits 3..0 side, index, write-protect, inward direction.
// - Second layout: status A bit 6 DMA request, bit 5 inverse latched step.
// - Second layout: status A bits 4..0 inverted track-zero, side, index, protect, direction.
// - First layout: status B bit 5 mirrors drive select bit 0.
// - Status B bits 4 and 3 toggle on write-data and read-data rising edges.
// - Status B bits 2..0 inverse write gate, motor B, motor A.
// - Hard reset pin clears every bit of the digital output control register.
module fcs_top #(
    parameter logic [7:0] SECTORS_OR_LAST_SECTOR = 8'h00
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    output logic irq,
    input wire logic hard_reset_pin,
    input wire logic track_zero_n,
    input wire logic index_n,
    input wire logic write_prot_n,
    input wire logic read_data_n,
    input wire logic second_drive_n,
    input wire logic disk_change_n,
    input wire logic write_data_n,
    input wire logic write_gate_n,
    input wire logic dma_req,
    output logic step_n,
    output logic dir_n,
    output logic head_n,
    output logic motor_a_on_n,
    output logic motor_b_on_n,
    output logic [1:0] drive_sel
);

    // ****************************************
    // Decode helpers
    // ****************************************

    // Opcode to command kind
    function automatic fcs_pkg::fcs_kind_t fcs_decode(input logic [7:0] op);
        if ((op & `FCS_RSEEK_MASK) == `FCS_OP_RSEEK) return fcs_pkg::K_RSEEK;
        if ((op & `FCS_LOCK_MASK) == `FCS_OP_LOCK) return fcs_pkg::K_LOCK;
        if (op == `FCS_OP_SINT) return fcs_pkg::K_SINT;
        if (op == `FCS_OP_SPEC) return fcs_pkg::K_SPEC;
        if (op == `FCS_OP_SEEK) return fcs_pkg::K_SEEK;
        if (op == `FCS_OP_CFG) return fcs_pkg::K_CFG;
        if (op == `FCS_OP_DUMP) return fcs_pkg::K_DUMP;
        if (op == `FCS_OP_PERP) return fcs_pkg::K_PERP;
        if (op == `FCS_OP_SDRV) return fcs_pkg::K_SDRV;
        return fcs_pkg::K_INV;
    endfunction

    // Parameter bytes that follow each opcode
    function automatic logic [1:0] fcs_plen(input fcs_pkg::fcs_kind_t k);
        case (k)
            fcs_pkg::K_SPEC, fcs_pkg::K_SEEK, fcs_pkg::K_RSEEK: return 2'd2;
            fcs_pkg::K_CFG: return 2'd3;
            fcs_pkg::K_PERP, fcs_pkg::K_SDRV: return 2'd1;
            default: return 2'd0;
        endcase
    endfunction

    // ****************************************
    // State
    // ****************************************

    fcs_pkg::fcs_state_t r;
    fcs_pkg::fcs_state_t n;
    fcs_pkg::fcs_pins_t pins_in;
    logic wf;
    logic [7:0] cur_pcn;

    // Raw pins gathered for the synchroniser
    assign pins_in = {hard_reset_pin, disk_change_n, second_drive_n, read_data_n,
                      write_prot_n, index_n, track_zero_n};
    assign wf = bus_wr && (bus_addr == `FCS_A_FIFO);
    assign cur_pcn = r.present_cylinder[r.drv];

    // Next state
    always_comb begin
        fcs_pkg::fcs_kind_t k;
        logic go;
        logic mkres;
        logic [2:0] ev;
        logic [2:0] clr;
        logic [2:0][7:0] pp;
        logic [7:0] base;
        k = r.kind;
        go = 1'b0;
        mkres = 1'b0;
        ev = 3'h0;
        clr = 3'h0;
        pp = r.p;
        base = 8'h00;
        n = r;
        n.rdata = 8'h00;

        // Two-stage pin synchroniser and edge toggles
        n.s1 = pins_in;
        n.s2 = r.s1;
        n.rd_prev = r.s2.rdata_n;
        n.wd_prev = write_data_n;
        if (r.s2.rdata_n && !r.rd_prev) begin
            n.rd_tog = ~r.rd_tog;
        end
        if (write_data_n && !r.wd_prev) begin
            n.wd_tog = ~r.wd_tog;
        end

        // Register reads
        if (bus_rd) begin
            case (bus_addr)
                `FCS_A_SA: begin
                    n.step_latch_n = 1'b1;
                    if (!r.layout) begin
                        n.rdata = {r.irq, r.s2.second_drive_n_n, ~r.step_n, r.s2.trk0_n,
                                   ~r.head_n, r.s2.index_n, r.s2.wp_n, ~r.dir_n};
                    end else begin
                        n.rdata = {r.irq, dma_req, ~r.step_latch_n, ~r.s2.trk0_n,
                                   r.head_n, ~r.s2.index_n, ~r.s2.wp_n, r.dir_n};
                    end
                end
                `FCS_A_SB: begin
                    n.rdata = {2'b00, r.dor[0], r.wd_tog, r.rd_tog,
                               ~write_gate_n, ~r.motb_n, ~r.mota_n};
                end
                `FCS_A_TD: n.rdata = {6'h00, r.td};
                `FCS_A_MS: begin
                    n.rdata = {r.st != fcs_pkg::ST_SEEK, r.st == fcs_pkg::ST_RESULT, 1'b0,
                               r.st == fcs_pkg::ST_PARAM || r.st == fcs_pkg::ST_RESULT, 4'h0};
                    if (r.st == fcs_pkg::ST_SEEK) begin
                        n.rdata[r.drv] = 1'b1;
                    end
                end
                `FCS_A_FIFO: begin
                    if (r.st == fcs_pkg::ST_RESULT) begin
                        n.rdata = r.res[r.res_i];
                        n.res_i = r.res_i + 4'h1;
                        if (r.res_i == r.res_n - 4'h1) begin
                            n.st = fcs_pkg::ST_IDLE;
                        end
                    end
                end
                `FCS_A_DI: begin
                    if (!r.layout) begin
                        n.rdata = {~r.s2.dskchg_n, 4'hF, r.rate, r.rate[0] ^ r.rate[1]};
                    end else begin
                        n.rdata = {r.s2.dskchg_n, 3'h7, r.dor[3], r.nopre, r.rate};
                    end
                end
                `FCS_A_ISTS: n.rdata = {5'h00, r.ists};
                `FCS_A_IMASK: n.rdata = {5'h00, r.imask};
                `FCS_A_MODE: n.rdata = {7'h00, r.layout};
                default: n.rdata = 8'h00;
            endcase
        end

        // Register writes and command bytes
        if (bus_wr) begin
            case (bus_addr)
                `FCS_A_DO: n.dor = bus_wdata;
                `FCS_A_TD: n.td = bus_wdata[1:0];
                `FCS_A_MS: n.rate = bus_wdata[1:0];
                `FCS_A_DI: begin
                    n.rate = bus_wdata[1:0];
                    n.nopre = bus_wdata[2];
                end
                `FCS_A_ISTS: clr = bus_wdata[2:0];
                `FCS_A_IMASK: n.imask = bus_wdata[2:0];
                `FCS_A_MODE: n.layout = bus_wdata[0];
                `FCS_A_FIFO: begin
                    if (r.st == fcs_pkg::ST_IDLE) begin
                        k = fcs_decode(bus_wdata);
                        n.kind = k;
                        n.rdir = bus_wdata[6];
                        n.pidx = 2'd0;
                        n.pleft = fcs_plen(k);
                        if (fcs_plen(k) == 2'd0) begin
                            go = 1'b1;
                        end else begin
                            n.st = fcs_pkg::ST_PARAM;
                        end
                    end else if (r.st == fcs_pkg::ST_PARAM) begin
                        pp[r.pidx] = bus_wdata;
                        n.p = pp;
                        n.pidx = r.pidx + 2'd1;
                        n.pleft = r.pleft - 2'd1;
                        go = (r.pleft == 2'd1);
                    end
                end
                default: ;
            endcase
        end

        // Command execution once the last byte is in
        if (go) begin
            n.st = fcs_pkg::ST_IDLE;
            case (k)
                fcs_pkg::K_SINT: begin
                    n.res[0] = r.st0;
                    n.res[1] = r.present_cylinder[r.drv];
                    n.res_n = 4'h2;
                    n.seek_pend = 1'b0;
                    mkres = 1'b1;
                end
                fcs_pkg::K_SPEC: begin
                    n.spec0 = pp[0];
                    n.spec1 = pp[1];
                end
                fcs_pkg::K_SEEK, fcs_pkg::K_RSEEK: begin
                    n.drv = pp[0][1:0];
                    n.head_n = ~pp[0][2];
                    base = r.present_cylinder[pp[0][1:0]];
                    if (k == fcs_pkg::K_SEEK) begin
                        n.tgt = pp[1];
                    end else if (r.rdir) begin
                        n.tgt = base + pp[1];
                    end else begin
                        n.tgt = base - pp[1];
                    end
                    n.stp_cnt = 8'h00;
                    n.st = fcs_pkg::ST_SEEK;
                end
                fcs_pkg::K_CFG: begin
                    n.cfg = {1'b0, pp[1][6:0]};
                    n.precomp_start_track = pp[2];
                end
                fcs_pkg::K_DUMP: begin
                    n.res[0] = r.present_cylinder[0];
                    n.res[1] = r.present_cylinder[1];
                    n.res[2] = r.present_cylinder[2];
                    n.res[3] = r.present_cylinder[3];
                    n.res[4] = r.spec0;
                    n.res[5] = r.spec1;
                    n.res[6] = SECTORS_OR_LAST_SECTOR;
                    n.res[7] = {r.lock, 1'b0, r.perp[5:0]};
                    n.res[8] = r.cfg;
                    n.res[9] = r.precomp_start_track;
                    n.res_n = `FCS_DUMP_LEN;
                    mkres = 1'b1;
                end
                fcs_pkg::K_PERP: begin
                    if (pp[0][7]) begin
                        n.perp = pp[0];
                    end else begin
                        n.perp = {r.perp[7:2], pp[0][1:0]};
                    end
                end
                fcs_pkg::K_LOCK: begin
                    n.lock = bus_wdata[7];
                    n.res[0] = {3'h0, bus_wdata[7], 4'h0};
                    n.res_n = 4'h1;
                    mkres = 1'b1;
                end
                fcs_pkg::K_SDRV: begin
                    n.res[0] = {1'b0, ~r.s2.wp_n, 1'b1, ~r.s2.trk0_n, 1'b1, pp[0][2:0]};
                    n.res_n = 4'h1;
                    mkres = 1'b1;
                end
                default: begin
                    n.res[0] = `FCS_ST0_INV;
                    n.res_n = 4'h1;
                    ev[`FCS_EV_INV] = 1'b1;
                    mkres = 1'b1;
                end
            endcase
        end

        // Result phase entry
        if (mkres) begin
            n.st = fcs_pkg::ST_RESULT;
            n.res_i = 4'h0;
            ev[`FCS_EV_RES] = 1'b1;
        end

        // Head stepping toward the target cylinder
        if (r.st == fcs_pkg::ST_SEEK) begin
            if (r.stp_cnt != 8'h00) begin
                n.stp_cnt = r.stp_cnt - 8'h01;
                if (r.stp_cnt == `FCS_STEP_LOW) begin
                    n.step_n = 1'b1;
                end
            end else if (r.present_cylinder[r.drv] == r.tgt) begin
                n.st = fcs_pkg::ST_IDLE;
                n.st0 = `FCS_ST0_SEEKEND | {5'h00, ~r.head_n, r.drv};
                n.seek_pend = 1'b1;
                ev[`FCS_EV_SEEK] = 1'b1;
            end else begin
                n.dir_n = ~(r.tgt > r.present_cylinder[r.drv]);
                n.step_n = 1'b0;
                n.step_latch_n = 1'b0;
                if (r.tgt > r.present_cylinder[r.drv]) begin
                    n.present_cylinder[r.drv] = r.present_cylinder[r.drv] + 8'h01;
                end else begin
                    n.present_cylinder[r.drv] = r.present_cylinder[r.drv] - 8'h01;
                end
                n.stp_cnt = 8'(`FCS_STEP_CYC);
            end
        end

        // Hard reset pin clears the output control register
        if (r.s2.mr) begin
            n.dor = 8'h00;
        end
        n.mota_n = ~n.dor[4];
        n.motb_n = ~n.dor[5];

        // Sticky events, set wins over clear
        n.ists = (r.ists & ~clr) | ev;
        n.irq = |(r.ists & r.imask);
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.step_n <= 1'b1;
            r.dir_n <= 1'b1;
            r.head_n <= 1'b1;
            r.mota_n <= 1'b1;
            r.motb_n <= 1'b1;
            r.step_latch_n <= 1'b1;
            r.s1.rdata_n <= 1'b1; // Data pins idle high, no false toggle after reset
            r.s2.rdata_n <= 1'b1;
            r.rd_prev <= 1'b1;
            r.wd_prev <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // Outputs
    assign bus_rdata = r.rdata;
    assign irq = r.irq;
    assign step_n = r.step_n;
    assign dir_n = r.dir_n;
    assign head_n = r.head_n;
    assign motor_a_on_n = r.mota_n;
    assign motor_b_on_n = r.motb_n;
    assign drive_sel = r.dor[1:0];

    // ****************************************
    // Assertions
    // ****************************************

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_op(logic [7:0] op);
        wf && r.st == fcs_pkg::ST_IDLE && bus_wdata == op;
    endsequence

    sequence s_par;
        wf && r.st == fcs_pkg::ST_PARAM;
    endsequence

    sense_int_a: assert property (
        s_op(`FCS_OP_SINT) |=> r.res_n == 4'h2 && r.res[1] == $past(cur_pcn) && r.st == fcs_pkg::ST_RESULT)
        else $error("sense interrupt result wrong");

    seek_take_a: assert property (
        s_op(`FCS_OP_SEEK) ##[1:4] s_par ##[1:4] s_par
        |=> r.st == fcs_pkg::ST_SEEK && r.tgt == $past(bus_wdata))
        else $error("seek target not taken");

    dump_len_a: assert property (
        s_op(`FCS_OP_DUMP) |=> r.res_n == 4'hA && r.res[0] == r.present_cylinder[0] && r.res[9] == r.precomp_start_track)
        else $error("register dump result wrong");

    sense_drv_a: assert property (
        s_op(`FCS_OP_SDRV) ##[1:4] s_par |=> r.st == fcs_pkg::ST_RESULT && r.res_n == 4'h1
            && (r.res[0] & 8'h07) == ($past(bus_wdata) & 8'h07))
        else $error("drive sense result wrong");

    invalid_cmd_a: assert property (
        wf && r.st == fcs_pkg::ST_IDLE && fcs_decode(bus_wdata) == fcs_pkg::K_INV
        |=> r.st == fcs_pkg::ST_RESULT && r.res_n == 4'h1 && r.res[0] == 8'h80)
        else $error("invalid opcode result wrong");

    sa_irq_a: assert property (
        bus_rd && bus_addr == `FCS_A_SA |=> bus_rdata[7] == $past(r.irq))
        else $error("status A bit 7 not interrupt level");

    sa_first_a: assert property (
        bus_rd && bus_addr == `FCS_A_SA && !r.layout
        |=> bus_rdata[5] != $past(r.step_n) && bus_rdata[4] == $past(r.s2.trk0_n)
            && bus_rdata[0] != $past(r.dir_n))
        else $error("status A first layout wrong");

    sa_second_a: assert property (
        bus_rd && bus_addr == `FCS_A_SA && r.layout
        |=> bus_rdata[6] == $past(dma_req) && bus_rdata[0] == $past(r.dir_n))
        else $error("status A second layout wrong");

    sb_mirror_a: assert property (
        bus_rd && bus_addr == `FCS_A_SB
        |=> bus_rdata[5] == $past(r.dor[0]) && bus_rdata[0] == $past(r.dor[4]))
        else $error("status B mirror wrong");

    rd_toggle_a: assert property (
        r.s2.rdata_n && !r.rd_prev |=> r.rd_tog != $past(r.rd_tog))
        else $error("read data toggle missed");

    do_clear_a: assert property (
        hard_reset_pin |-> ##3 r.dor == 8'h00 && motor_a_on_n && motor_b_on_n)
        else $error("hard reset did not clear output control");

    cfg_take_a: assert property (
        s_op(`FCS_OP_CFG) ##[1:4] s_par ##[1:4] s_par ##[1:4] s_par
        |=> r.st == fcs_pkg::ST_IDLE && r.precomp_start_track == $past(bus_wdata))
        else $error("configure not applied");

    lock_res_a: assert property (
        s_op(`FCS_OP_LOCK) or s_op(`FCS_OP_LOCK | 8'h80)
        |=> r.res[0] == (($past(bus_wdata) & 8'h80) >> 3) && r.res_n == 4'h1)
        else $error("lock result wrong");

    irq_level_a: assert property (
        |(r.ists & r.imask) |=> irq)
        else $error("interrupt output not raised");

endmodule
